/* File: rtl/rzl_pkg.sv */
package rzl_pkg;

  // ----------------------------------------------------------------------
  // Nonvolatile store layout
  // ----------------------------------------------------------------------
  localparam int          PROM_WORDS   = 10400;
  localparam int          PROM_DW      = 36;
  localparam int          PROM_AW      = 14;
  localparam int          CLIENT_WORDS = 820;
  localparam int          PROM_FREE    = PROM_WORDS - CLIENT_WORDS;
  localparam logic [13:0] CLIENT_BASE  = 14'h0000;
  localparam logic [13:0] CLIENT_LAST  = 14'(CLIENT_WORDS - 1);

  // ----------------------------------------------------------------------
  // Embedded RAM population and geometry
  // ----------------------------------------------------------------------
  localparam int          N_BLK        = 3;
  localparam logic [1:0]  BLK_DP_LARGE = 2'h0;
  localparam logic [1:0]  BLK_TP_LARGE = 2'h1;
  localparam logic [1:0]  BLK_MICRO    = 2'h2;
  localparam int          RAM_DW       = 36;
  localparam int          RAM_DEPTH    = 512;

  typedef enum logic {
    RZL_ST_FILL,
    RZL_ST_RUN
  } rzl_state_e;

  // Client content: the zero pattern, whatever word is fetched
  function automatic logic [PROM_DW-1:0] rzl_client_word(
    input logic [PROM_AW-1:0] addr
  );
    rzl_client_word = {PROM_DW{1'b0}} & {PROM_DW{addr[0]}};
  endfunction : rzl_client_word

  // Next fetch address, wrapping inside the client's span
  function automatic logic [PROM_AW-1:0] rzl_prom_next(
    input logic [PROM_AW-1:0] addr
  );
    rzl_prom_next = (addr == CLIENT_BASE + CLIENT_LAST) ? CLIENT_BASE
                                                        : addr + 14'h0001;
  endfunction : rzl_prom_next

endpackage : rzl_pkg

/* File: rtl/rzl_ram_if.sv */
`timescale 1ns/10ps
interface rzl_ram_if #(
  parameter int DW = 36,
  parameter int AW = 9
);
  logic          wr;
  logic          init_wr;
  logic          rd;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic          rinit;

  modport ctl (output wr, init_wr, rd, addr, wdata, input rdata, rinit);
  modport ram (input wr, init_wr, rd, addr, wdata, output rdata, rinit);
endinterface : rzl_ram_if

/* File: rtl/rzl_ram.sv */
`timescale 1ns/10ps
module rzl_ram #(
  parameter int DEPTH = 512
) (
  input  wire logic core_clk,
  rzl_ram_if.ram    bus
);
  // Untouched flag per word: set by the fill, cleared by a user write
  logic [rzl_pkg::RAM_DW-1:0] mem_r   [DEPTH];
  logic                       untch_r [DEPTH];
  logic [rzl_pkg::RAM_DW-1:0] rdata_r;
  logic                       rinit_r;

  // Read-first: a read in the same cycle as a write sees the old word
  always_ff @(posedge core_clk) begin
    if (bus.wr) begin
      mem_r[bus.addr]   <= bus.wdata;
      untch_r[bus.addr] <= bus.init_wr;
    end
    if (bus.rd) begin
      rdata_r <= mem_r[bus.addr];
      rinit_r <= untch_r[bus.addr];
    end
  end

  assign bus.rdata = rdata_r;
  assign bus.rinit = rinit_r;
endmodule : rzl_ram

/* File: rtl/rzl_loader.sv */
`timescale 1ns/10ps
module rzl_loader
  import rzl_pkg::*;
#(
  parameter int DEPTH = rzl_pkg::RAM_DEPTH,
  parameter int AW    = $clog2(rzl_pkg::RAM_DEPTH)
) (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         device_reset_pin_low,
  input  wire logic                         user_wr,
  input  wire logic                         user_rd,
  input  wire logic [1:0]                   user_sel,
  input  wire logic [AW-1:0]                user_addr,
  input  wire logic [rzl_pkg::RAM_DW-1:0]   user_wdata,
  input  wire logic                         user_ecc_en,
  output logic                              init_busy,
  output logic [rzl_pkg::PROM_AW-1:0]       prom_addr,
  output logic                              rd_valid,
  output logic [rzl_pkg::RAM_DW-1:0]        rd_data,
  output logic                              single_bit_corrected_flag,
  output logic                              double_bit_detected_flag
);
  import rzl_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rzl_state_e              state_r,    state_nxt;
  logic [AW-1:0]           idx_r,      idx_nxt;
  logic [PROM_AW-1:0]      prom_r,     prom_nxt;
  logic                    busy_r,     busy_nxt;
  logic                    rd_req_r,   rd_req_nxt;
  logic [1:0]              rd_sel_r,   rd_sel_nxt;
  logic                    rd_ecc_r,   rd_ecc_nxt;
  logic                    rd_valid_r, rd_valid_nxt;
  logic [RAM_DW-1:0]       rd_data_r,  rd_data_nxt;
  logic                    sbc_r,      sbc_nxt;
  logic                    dbd_r,      dbd_nxt;

  logic                    filling;
  logic                    take_wr;
  logic                    take_rd;
  logic [RAM_DW-1:0]       fill_word;
  logic [N_BLK-1:0]        blk_wr;
  logic [RAM_DW-1:0]       blk_rdata [N_BLK];
  logic [N_BLK-1:0]        blk_rinit;

  // Fill only runs while the reset pin is released
  assign filling   = (state_r == RZL_ST_FILL) && device_reset_pin_low;
  assign take_wr   = user_wr && !busy_r && device_reset_pin_low;
  assign take_rd   = user_rd && !busy_r && device_reset_pin_low;
  assign fill_word = rzl_client_word(prom_r);

  // ----------------------------------------------------------------------
  // Broadcast port: one shared fill write strobe for every block, user writes per block
  // ----------------------------------------------------------------------
  for (genvar b = 0; b < N_BLK; b++) begin : g_blk
    rzl_ram_if #(.DW(RAM_DW), .AW(AW)) bus ();

    // All blocks see the same fill write in the same cycle
    assign bus.wr      = filling || (take_wr && user_sel == 2'(b));
    assign bus.init_wr = filling;
    assign bus.rd      = take_rd && user_sel == 2'(b);
    assign bus.addr    = filling ? idx_r : user_addr;
    assign bus.wdata   = filling ? fill_word : user_wdata;
    assign blk_wr[b]   = bus.wr;
    assign blk_rdata[b] = bus.rdata;
    assign blk_rinit[b] = bus.rinit;

    // Instances: dual-port large, two-port large, micro
    rzl_ram #(.DEPTH(DEPTH)) u_ram (
      .core_clk (core_clk),
      .bus      (bus.ram)
    );
  end

  // ----------------------------------------------------------------------
  // Fill sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    prom_nxt  = prom_r;
    case (state_r)
      RZL_ST_FILL: begin
        if (filling) begin
          idx_nxt  = idx_r + AW'(1);
          prom_nxt = rzl_prom_next(prom_r);
          if (idx_r == AW'(DEPTH - 1)) begin
            state_nxt = RZL_ST_RUN;
          end
        end
      end
      RZL_ST_RUN: begin
      end
      default: begin
        state_nxt = RZL_ST_FILL;
      end
    endcase
    // Pin reset restarts the fill from the first word
    if (!device_reset_pin_low) begin
      state_nxt = RZL_ST_FILL;
      idx_nxt   = '0;
      prom_nxt  = CLIENT_BASE;
    end
    busy_nxt = (state_nxt == RZL_ST_FILL);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= RZL_ST_FILL;
      idx_r   <= '0;
      prom_r  <= CLIENT_BASE;
      busy_r  <= 1'b1;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      prom_r  <= prom_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Read return and error flags
  // ----------------------------------------------------------------------
  always_comb begin
    rd_req_nxt   = take_rd;
    rd_sel_nxt   = take_rd ? user_sel : rd_sel_r;
    rd_ecc_nxt   = take_rd ? user_ecc_en : rd_ecc_r;
    rd_valid_nxt = rd_req_r;
    rd_data_nxt  = rd_data_r;
    sbc_nxt      = sbc_r;
    dbd_nxt      = dbd_r;
    if (rd_req_r) begin
      rd_data_nxt = blk_rdata[rd_sel_r];
      // Zero loaded by the fill has no valid check bits, so ECC calls it corrupt
      sbc_nxt = rd_ecc_r && blk_rinit[rd_sel_r];
      dbd_nxt = rd_ecc_r && blk_rinit[rd_sel_r];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_req_r   <= 1'b0;
      rd_sel_r   <= BLK_DP_LARGE;
      rd_ecc_r   <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
      sbc_r      <= 1'b0;
      dbd_r      <= 1'b0;
    end else begin
      rd_req_r   <= rd_req_nxt;
      rd_sel_r   <= rd_sel_nxt;
      rd_ecc_r   <= rd_ecc_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r  <= rd_data_nxt;
      sbc_r      <= sbc_nxt;
      dbd_r      <= dbd_nxt;
    end
  end

  assign init_busy                 = busy_r;
  assign prom_addr                 = prom_r;
  assign rd_valid                  = rd_valid_r;
  assign rd_data                   = rd_data_r;
  assign single_bit_corrected_flag = sbc_r;
  assign double_bit_detected_flag  = dbd_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_take_wr;
    take_wr && !user_rd;
  endsequence

  sequence s_reread;
    take_rd && !user_wr && user_addr == $past(user_addr)
      && user_sel == $past(user_sel);
  endsequence

  a_busy_after_rst: assert property (
    $rose(device_reset_pin_low) |-> busy_r [*2])
    else $error("fill not restarted after pin reset");

  a_fill_end: assert property (
    $fell(busy_r) |-> $past(idx_r) == AW'(DEPTH - 1))
    else $error("fill ended before the last word");

  a_bcast_all: assert property (
    filling |-> (&blk_wr) && fill_word == '0)
    else $error("fill write not broadcast as zero");

  a_no_user_fill: assert property (
    busy_r && user_wr |-> !take_wr && (filling || !(|blk_wr)))
    else $error("user write let through during fill");

  a_rd_latency: assert property (
    take_rd && !rd_req_r |=> !rd_valid_r ##1 rd_valid_r)
    else $error("read data not returned two cycles later");

  a_flag_zero: assert property (
    rd_valid_r && sbc_r |-> dbd_r && rd_data_r == '0)
    else $error("error flags without the stored zero");

  a_flag_clear: assert property (
    s_take_wr ##1 s_reread |=> ##1 !sbc_r && !dbd_r)
    else $error("flags stayed set after a write");

  a_prom_span: assert property (
    busy_r |-> prom_r <= CLIENT_BASE + CLIENT_LAST)
    else $error("fetch outside the zero client");

  a_prom_room: assert property (
    32'(prom_r) + PROM_FREE < PROM_WORDS && PROM_FREE == 9580)
    else $error("zero client overlaps free store space");

endmodule : rzl_loader

/* File: sim/rzl_ram_model.sv */
`timescale 1ns/10ps
module rzl_ram_model #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic                      core_clk,
  input  wire logic                      clear,
  input  wire logic                      wr,
  input  wire logic [1:0]                sel,
  input  wire logic [AW-1:0]             addr,
  input  wire logic [rzl_pkg::RAM_DW-1:0] wdata,
  output logic      [rzl_pkg::RAM_DW-1:0] exp_data,
  output logic                           exp_fresh
);
  import rzl_pkg::*;
  logic [RAM_DW-1:0] mem_r   [N_BLK][DEPTH];
  logic              fresh_r [N_BLK][DEPTH];

  // Whole-array clear stands in for the broadcast fill
  always @(posedge core_clk) begin
    if (clear) begin
      for (int b = 0; b < N_BLK; b++) begin
        for (int a = 0; a < DEPTH; a++) begin
          mem_r[b][a]   <= '0;
          fresh_r[b][a] <= 1'b1;
        end
      end
    end else if (wr && sel < 2'h3) begin
      mem_r[sel][addr]   <= wdata;
      fresh_r[sel][addr] <= 1'b0;
    end
  end

  assign exp_data  = (sel < 2'h3) ? mem_r[sel][addr] : '0;
  assign exp_fresh = (sel < 2'h3) ? fresh_r[sel][addr] : 1'b0;
endmodule : rzl_ram_model

/* File: sim/test_ram_zero_init_loader.sv */
`timescale 1ns/10ps
module test_ram_zero_init_loader;
  import rzl_pkg::*;
  localparam int DEPTH = 16;
  localparam int AW    = 4;
  logic                core_clk, sys_rst, device_reset_pin_low;
  logic                user_wr, user_rd, user_ecc_en, fill_done;
  logic [1:0]          user_sel;
  logic [AW-1:0]       user_addr;
  logic [RAM_DW-1:0]   user_wdata, rd_data, exp_data;
  logic [PROM_AW-1:0]  prom_addr;
  logic                init_busy, rd_valid, sb_flag, db_flag, exp_fresh;
  int                  num_errors, checked;
  int                  cycles = 0;

  rzl_loader #(.DEPTH(DEPTH), .AW(AW)) rzl_loader_i (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .device_reset_pin_low(device_reset_pin_low), .user_wr(user_wr),
    .user_rd(user_rd), .user_sel(user_sel), .user_addr(user_addr),
    .user_wdata(user_wdata), .user_ecc_en(user_ecc_en),
    .init_busy(init_busy), .prom_addr(prom_addr), .rd_valid(rd_valid),
    .rd_data(rd_data), .single_bit_corrected_flag(sb_flag),
    .double_bit_detected_flag(db_flag));

  rzl_ram_model #(.DEPTH(DEPTH), .AW(AW)) rzl_ram_model_i (
    .core_clk(core_clk), .clear(sys_rst | ~device_reset_pin_low),
    .wr(user_wr & fill_done), .sel(user_sel), .addr(user_addr),
    .wdata(user_wdata), .exp_data(exp_data), .exp_fresh(exp_fresh));

  // ----------------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------------
  always #50 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end

  task automatic check(input string n, input logic [RAM_DW-1:0] s, e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic results();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  // Edges are counted from the edge that drove the release; n0 of them
  // have already passed when the task is entered
  task automatic wait_fill(input int n0);
    int n;
    n = n0;
    while (init_busy !== 1'b0 && n < DEPTH + 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("fill_len", 36'(n), 36'(DEPTH));
    check("prom_addr_end", 36'(prom_addr), 36'(CLIENT_BASE) + 36'(DEPTH));
    fill_done = 1'b1;
  endtask : wait_fill

  task automatic wr_word(input logic [1:0] s, input logic [AW-1:0] a,
                         input logic [RAM_DW-1:0] d);
    @(posedge core_clk);
    user_wr <= 1'b1;
    user_sel <= s;
    user_addr <= a;
    user_wdata <= d;
    @(posedge core_clk);
    user_wr <= 1'b0;
  endtask : wr_word

  task automatic rd_check(input logic [1:0] s, input logic [AW-1:0] a,
                          input logic ecc);
    logic [RAM_DW-1:0] ed;
    logic              ef;
    @(posedge core_clk);
    user_rd <= 1'b1;
    user_sel <= s;
    user_addr <= a;
    user_ecc_en <= ecc;
    #1;
    ed = exp_data;
    ef = exp_fresh & ecc;
    @(posedge core_clk);
    user_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    check("rd_valid", 36'(rd_valid), 36'h1);
    check("rd_data", rd_data, ed);
    check("sb_flag", 36'(sb_flag), 36'(ef));
    check("db_flag", 36'(db_flag), 36'(ef));
  endtask : rd_check

  // Write, then read the same word in the very next cycle
  task automatic wr_rd_check(input logic [1:0] s, input logic [AW-1:0] a,
                             input logic [RAM_DW-1:0] d);
    logic [RAM_DW-1:0] ed;
    logic              ef;
    @(posedge core_clk);
    user_wr <= 1'b1;
    user_sel <= s;
    user_addr <= a;
    user_wdata <= d;
    @(posedge core_clk);
    user_wr <= 1'b0;
    user_rd <= 1'b1;
    user_ecc_en <= 1'b1;
    #1;
    ed = exp_data;
    ef = exp_fresh;
    @(posedge core_clk);
    user_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    check("wr_rd_valid", 36'(rd_valid), 36'h1);
    check("wr_rd_data", rd_data, ed);
    check("wr_rd_sb", 36'(sb_flag), 36'(ef));
    check("wr_rd_db", 36'(db_flag), 36'(ef));
  endtask : wr_rd_check

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Write and read attempted mid-fill must both vanish
  task automatic test_reset_busy();
    fill_done = 1'b0;
    sys_rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    check("busy_in_rst", 36'(init_busy), 36'h1);
    check("prom_addr", 36'(prom_addr), 36'(CLIENT_BASE));
    wr_word(2'h0, 4'h2, 36'h5A5A5A5A5);
    user_rd <= 1'b1;
    repeat (3) @(posedge core_clk);
    user_rd <= 1'b0;
    #1;
    check("rd_valid_busy", 36'(rd_valid), 36'h0);
    wait_fill(5);
    rd_check(2'h0, 4'h2, 1'b1);
  endtask : test_reset_busy

  task automatic test_all_zero();
    for (int b = 0; b < N_BLK; b++) begin
      rd_check(2'(b), 4'h0, 1'b1);
      rd_check(2'(b), 4'(DEPTH - 1), 1'b1);
    end
    rd_check(2'h1, 4'h6, 1'b0);
  endtask : test_all_zero

  task automatic test_write_clear();
    wr_word(2'h1, 4'h3, 36'hABC123456);
    rd_check(2'h1, 4'h3, 1'b1);
    rd_check(2'h1, 4'h4, 1'b1);
    rd_check(2'h0, 4'h3, 1'b1);
    wr_rd_check(2'h2, 4'h5, 36'h0F0F0F0F0);
    rd_check(2'h2, 4'h5, 1'b1);
  endtask : test_write_clear

  task automatic test_pin_restart();
    wr_word(2'h2, 4'h7, 36'hFFFFFFFFF);
    @(posedge core_clk);
    device_reset_pin_low <= 1'b0;
    fill_done = 1'b0;
    wr_word(2'h0, 4'h1, 36'h123456789);
    device_reset_pin_low <= 1'b1;
    #1;
    check("busy_pin_low", 36'(init_busy), 36'h1);
    wait_fill(0);
    rd_check(2'h2, 4'h7, 1'b1);
    rd_check(2'h0, 4'h1, 1'b1);
  endtask : test_pin_restart

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    device_reset_pin_low = 1'b1;
    {user_wr, user_rd, user_ecc_en, fill_done} = 4'h0;
    user_sel = 2'h0;
    user_addr = '0;
    user_wdata = '0;
    {num_errors, checked} = '0;
    test_reset_busy();
    test_all_zero();
    test_write_clear();
    test_pin_restart();
    results();
  end
endmodule : test_ram_zero_init_loader
